// [ppi_page_buf.sv]
// four-entry page buffer holding address/data pairs for a page write
`timescale 1ns/10ps
`include "ppi_params.svh"

module ppi_page_buf
  import ppi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_idx,
  input  wire logic [24:0] wr_word,
  input  wire logic [1:0]  rd_idx,
  output logic      [24:0] rd_word
);

  ppi_buf_t b_r;
  ppi_buf_t b_nxt;

  // ----------------------------------------------------------------
  // next state: write port and registered read
  // ----------------------------------------------------------------
  always_comb begin
    b_nxt = b_r;
    if (wr_en) begin
      b_nxt.words[wr_idx] = wr_word;
    end
    b_nxt.q = b_r.words[rd_idx];
  end

  // no reset: contents are always written before a page command
  always_ff @(posedge clk) begin
    b_r <= b_nxt;
  end

  assign rd_word = b_r.q;

endmodule

// [ppi_params.svh]
// timing counts, address limits and field values for the prom programmer
`ifndef PPI_PARAMS_SVH
`define PPI_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PPI_CLK_MHZ     50
`define PPI_PULSE_US    100
`define PPI_PULSE_CYC   (`PPI_PULSE_US * `PPI_CLK_MHZ)
`define PPI_SETUP_NS    1000
`define PPI_SETUP_CYC   ((`PPI_SETUP_NS * `PPI_CLK_MHZ + 999) / 1000)
`define PPI_ACCESS_NS   500
`define PPI_ACCESS_CYC  ((`PPI_ACCESS_NS * `PPI_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// limits and values
// ----------------------------------------------------------------
`define PPI_MAX_TRIES   4'ha
`define PPI_ADDR_LAST   17'h0_efff
`define PPI_ERASED      8'hff
`define PPI_LAST_IDX    2'h3
`define PPI_ADDR_W      17
`define PPI_DATA_W      8

`endif

// [ppi_pkg.sv]
// types shared by the prom programmer and its page buffer
package ppi_pkg;

  // one-hot sequencer states
  typedef enum logic [5:0] {
    PPI_ST_IDLE   = 6'h01,
    PPI_ST_SETUP  = 6'h02,
    PPI_ST_LATCH  = 6'h04,
    PPI_ST_PULSE  = 6'h08,
    PPI_ST_GAP    = 6'h10,
    PPI_ST_VERIFY = 6'h20
  } ppi_st_t;

  // user commands
  typedef enum logic [1:0] {
    PPI_OP_READ = 2'h0,
    PPI_OP_BYTE = 2'h1,
    PPI_OP_PAGE = 2'h2,
    PPI_OP_NONE = 2'h3
  } ppi_op_t;

  // page buffer state: four address/data words and a read register
  typedef struct packed {
    logic [3:0][24:0] words;
    logic [24:0]      q;
  } ppi_buf_t;

  // controller state
  typedef struct packed {
    ppi_st_t     state;
    ppi_op_t     op;
    logic [15:0] cnt;
    logic [1:0]  idx;
    logic [3:0]  tries;
    logic        mism;
    logic [16:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic        prom_reset_n;
    logic        vpp_high;
    logic        ce_n;
    logic        oe_n;
    logic        pgm_n;
    logic [16:0] pa;
    logic [7:0]  pd;
    logic        pd_oe_n;
    logic        busy;
    logic        done;
    logic        fail;
    logic [7:0]  rd_data;
    logic        blank;
  } ppi_state_t;

endpackage

// [ppi_prom_model.sv]
// behavioural model of the prom device as seen at its programming pins
`timescale 1ns/10ps

module ppi_prom_model (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        vpp_high,
  input  wire logic        enable_n,
  input  wire logic        read_n,
  input  wire logic        pgm_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  din,
  output logic             dq_en,
  output logic      [7:0]  dq
);
  logic [7:0]  mem [0:131071];
  logic [24:0] page [0:3];
  logic [7:0]  last;
  logic        pgm_d;
  int          skip = 0;
  int          pulses = 0;
  int          width = 0;
  int          low = 0;

  // ----------------------------------------------------------------
  // output side
  // ----------------------------------------------------------------
  // every cell starts erased
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
    last = 8'h00;
    pgm_d = 1'b1;
  end
  // only read or verify drives; a released bus shows the inverse of its last value
  assign dq_en = !reset_n && !enable_n && !read_n && pgm_n;
  assign dq    = dq_en ? mem[addr] : ~last;

  // ----------------------------------------------------------------
  // programming side
  // ----------------------------------------------------------------
  // writes need programming mode and the high supply; a cell only loses ones,
  // and skip lets the bench make a cell refuse a given number of pulses
  always @(posedge clk) begin
    last  <= din;
    pgm_d <= pgm_n;
    low   <= pgm_n ? 0 : low + 1;
    if (!reset_n && vpp_high && enable_n && !read_n && pgm_n) begin
      page[addr[1:0]] <= {addr, din};
    end
    if (pgm_n && !pgm_d) begin
      width <= low;
    end
    if (!reset_n && vpp_high && !pgm_n && pgm_d && read_n) begin
      pulses <= pulses + 1;
      if (skip > 0) begin
        skip <= skip - 1;
      end else if (enable_n) begin
        for (int k = 0; k < 4; k++) mem[page[k][24:8]] &= page[k][7:0];
      end else begin
        mem[addr] &= din;
      end
    end
  end
endmodule

// [ppi_prom_prog.sv]
// controller that drives the prom programming pins: read, byte and page write
`timescale 1ns/10ps
`include "ppi_params.svh"

module ppi_prom_prog
  import ppi_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `PPI_PULSE_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_op,
  input  wire logic [16:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        pg_wr_en,
  input  wire logic [1:0]  pg_wr_idx,
  input  wire logic [16:0] pg_wr_addr,
  input  wire logic [7:0]  pg_wr_data,
  output logic             busy,
  output logic             done,
  output logic             fail,
  output logic      [7:0]  rd_data,
  output logic             rd_blank,
  output logic             prom_reset_n,
  output logic             vpp_high,
  output logic             prom_enable_n,
  output logic             read_strobe_n,
  output logic             program_pulse_n,
  output logic      [16:0] prog_address,
  output logic      [7:0]  prog_data_out,
  output logic             prog_data_oe_n,
  input  wire logic [7:0]  prog_data_in
);
  // ----------------------------------------------------------------
  // constants and helpers
  // ----------------------------------------------------------------
  localparam logic [15:0] SETUP_LD  = 16'(`PPI_SETUP_CYC - 1);
  localparam logic [15:0] ACCESS_LD = 16'(`PPI_ACCESS_CYC - 1);
  localparam logic [15:0] PULSE_LD  = 16'(PULSE_CYC - 1);
  // reset value: standby, device not yet in programming mode
  localparam ppi_state_t S_RST = '{
    state: PPI_ST_IDLE, op: PPI_OP_READ, cnt: 16'h0000, idx: 2'h0,
    tries: 4'h0, mism: 1'b0, addr: 17'h0_0000, wdata: 8'h00,
    sync1: 8'h00, sync2: 8'h00, prom_reset_n: 1'b1, vpp_high: 1'b0,
    ce_n: 1'b1, oe_n: 1'b1, pgm_n: 1'b1, pa: 17'h0_0000, pd: 8'h00,
    pd_oe_n: 1'b1, busy: 1'b0, done: 1'b0, fail: 1'b0, rd_data: 8'h00,
    blank: 1'b0};
  // a write target must lie in the programmable range
  function automatic logic addr_ok(input logic [16:0] a);
    addr_ok = (a <= `PPI_ADDR_LAST);
  endfunction
  ppi_state_t  s_r;
  ppi_state_t  s_nxt;
  logic [24:0] buf_word;
  logic [16:0] buf_addr;
  logic [7:0]  buf_data;
  assign buf_addr = buf_word[24:8];
  assign buf_data = buf_word[7:0];

  // ----------------------------------------------------------------
  // page buffer; user writes are ignored while a command runs
  // ----------------------------------------------------------------
  ppi_page_buf u_buf (
    .clk     (clk),
    .wr_en   (pg_wr_en & ~s_r.busy),
    .wr_idx  (pg_wr_idx),
    .wr_word ({pg_wr_addr, pg_wr_data}),
    .rd_idx  (s_r.idx),
    .rd_word (buf_word)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic       fin;
    logic       mism_now;
    logic [7:0] expect_d;
    fin      = 1'b0;
    mism_now = 1'b0;
    expect_d = (s_r.op == PPI_OP_PAGE) ? buf_data : s_r.wdata;
    s_nxt       = s_r;
    s_nxt.done  = 1'b0;
    // data pins pass two flops; only the second is compared
    s_nxt.sync1 = prog_data_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.cnt   = (s_r.cnt != 16'h0000) ? s_r.cnt - 16'h0001 : 16'h0000;
    case (s_r.state)
      PPI_ST_IDLE: begin
        if (cmd_valid) begin
          s_nxt.busy         = 1'b1;
          s_nxt.fail         = 1'b0;
          s_nxt.op           = ppi_op_t'(cmd_op);
          s_nxt.addr         = cmd_addr;
          s_nxt.wdata        = cmd_data;
          s_nxt.tries        = 4'h0;
          s_nxt.prom_reset_n = 1'b0;
          s_nxt.vpp_high     = (cmd_op != PPI_OP_READ);
          s_nxt.pa           = cmd_addr;
          s_nxt.cnt          = SETUP_LD;
          s_nxt.state        = PPI_ST_SETUP;
          if (cmd_op == PPI_OP_NONE || (cmd_op == PPI_OP_BYTE && !addr_ok(cmd_addr))) begin
            s_nxt.fail = 1'b1;
            fin        = 1'b1;
          end
        end
      end
      PPI_ST_SETUP: begin
        // supply and address settle with every strobe inactive
        s_nxt.ce_n    = 1'b1;
        s_nxt.oe_n    = 1'b1;
        s_nxt.pgm_n   = 1'b1;
        s_nxt.pd_oe_n = 1'b1;
        s_nxt.idx     = 2'h0;
        s_nxt.mism    = 1'b0;
        if (s_r.cnt == 16'h0000) begin
          case (s_r.op)
            PPI_OP_READ: begin
              s_nxt.ce_n  = 1'b0;
              s_nxt.oe_n  = 1'b0;
              s_nxt.cnt   = ACCESS_LD;
              s_nxt.state = PPI_ST_VERIFY;
            end
            PPI_OP_BYTE: begin
              s_nxt.ce_n    = 1'b0;
              s_nxt.pgm_n   = 1'b0;
              s_nxt.pd      = s_r.wdata;
              s_nxt.pd_oe_n = 1'b0;
              s_nxt.pa      = s_r.addr;
              s_nxt.cnt     = PULSE_LD;
              s_nxt.state   = PPI_ST_PULSE;
            end
            default: begin
              s_nxt.oe_n    = 1'b0;
              s_nxt.pd_oe_n = 1'b0;
              s_nxt.cnt     = SETUP_LD;
              s_nxt.state   = PPI_ST_LATCH;
            end
          endcase
        end
      end
      PPI_ST_LATCH: begin
        // buffer read lags one cycle; the hold time covers it
        s_nxt.pa = buf_addr;
        s_nxt.pd = buf_data;
        if (s_r.cnt == 16'h0000) begin
          if (!addr_ok(buf_addr)) begin
            s_nxt.fail = 1'b1;
            fin        = 1'b1;
          end else if (s_r.idx == `PPI_LAST_IDX) begin
            s_nxt.oe_n    = 1'b1;
            s_nxt.pgm_n   = 1'b0;
            s_nxt.pd_oe_n = 1'b1;
            s_nxt.cnt     = PULSE_LD;
            s_nxt.state   = PPI_ST_PULSE;
          end else begin
            s_nxt.idx = s_r.idx + 2'h1;
            s_nxt.cnt = SETUP_LD;
          end
        end
      end
      PPI_ST_PULSE: begin
        if (s_r.cnt == 16'h0000) begin
          s_nxt.pgm_n   = 1'b1;
          s_nxt.pd_oe_n = 1'b1;
          s_nxt.cnt     = SETUP_LD;
          s_nxt.state   = PPI_ST_GAP;
        end
      end
      PPI_ST_GAP: begin
        if (s_r.cnt == 16'h0000) begin
          s_nxt.ce_n  = 1'b0;
          s_nxt.oe_n  = 1'b0;
          s_nxt.idx   = 2'h0;
          s_nxt.cnt   = ACCESS_LD;
          s_nxt.state = PPI_ST_VERIFY;
        end
      end
      PPI_ST_VERIFY: begin
        if (s_r.op == PPI_OP_PAGE) begin
          s_nxt.pa = buf_addr;
        end
        if (s_r.cnt == 16'h0000) begin
          mism_now = s_r.mism | (s_r.sync2 != expect_d);
          if (s_r.op == PPI_OP_READ) begin
            s_nxt.rd_data = s_r.sync2;
            s_nxt.blank   = (s_r.sync2 == `PPI_ERASED);
            fin           = 1'b1;
          end else if (s_r.op == PPI_OP_PAGE && s_r.idx != `PPI_LAST_IDX) begin
            s_nxt.idx  = s_r.idx + 2'h1;
            s_nxt.mism = mism_now;
            s_nxt.cnt  = ACCESS_LD;
          end else if (!mism_now) begin
            fin = 1'b1;
          end else if (s_r.tries == `PPI_MAX_TRIES - 4'h1) begin
            s_nxt.fail = 1'b1;
            fin        = 1'b1;
          end else begin
            // write again: setup drops the strobes and repeats the pulse
            s_nxt.tries = s_r.tries + 4'h1;
            s_nxt.ce_n  = 1'b1;
            s_nxt.oe_n  = 1'b1;
            s_nxt.cnt   = SETUP_LD;
            s_nxt.state = PPI_ST_SETUP;
          end
        end
      end
      default: begin
        fin = 1'b1;
      end
    endcase
    // finishing returns the device to standby, reset still low
    if (fin) begin
      s_nxt.ce_n     = 1'b1;
      s_nxt.oe_n     = 1'b1;
      s_nxt.pgm_n    = 1'b1;
      s_nxt.pd_oe_n  = 1'b1;
      s_nxt.vpp_high = 1'b0;
      s_nxt.busy     = 1'b0;
      s_nxt.done     = 1'b1;
      s_nxt.state    = PPI_ST_IDLE;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign busy            = s_r.busy;
  assign done            = s_r.done;
  assign fail            = s_r.fail;
  assign rd_data         = s_r.rd_data;
  assign rd_blank        = s_r.blank;
  assign prom_reset_n    = s_r.prom_reset_n;
  assign vpp_high        = s_r.vpp_high;
  assign prom_enable_n   = s_r.ce_n;
  assign read_strobe_n   = s_r.oe_n;
  assign program_pulse_n = s_r.pgm_n;
  assign prog_address    = s_r.pa;
  assign prog_data_out   = s_r.pd;
  assign prog_data_oe_n  = s_r.pd_oe_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] pulse_len_r;
  // counts the cycles of the current program pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_len_r <= 16'h0000;
    end else begin
      pulse_len_r <= s_r.pgm_n ? 16'h0000 : pulse_len_r + 16'h0001;
    end
  end
  sequence seq_page_pulse;
    s_r.ce_n && s_r.oe_n && !s_r.pgm_n;
  endsequence
  sequence seq_byte_pulse;
    !s_r.ce_n && s_r.oe_n && !s_r.pgm_n;
  endsequence
  a_pulse_width: assert property (@(posedge clk) disable iff (rst)
    $rose(s_r.pgm_n) |-> pulse_len_r == 16'(PULSE_CYC))
    else $error("program pulse length wrong");
  a_page_release: assert property (@(posedge clk) disable iff (rst)
    seq_page_pulse |-> s_r.pd_oe_n)
    else $error("data bus driven during page pulse");
  a_byte_drive: assert property (@(posedge clk) disable iff (rst)
    seq_byte_pulse |-> !s_r.pd_oe_n && s_r.pd == s_r.wdata)
    else $error("byte data not driven during pulse");
  a_latch_levels: assert property (@(posedge clk) disable iff (rst)
    s_r.state == PPI_ST_LATCH |-> s_r.ce_n && !s_r.oe_n && s_r.pgm_n && !s_r.pd_oe_n)
    else $error("page latch strobes wrong");
  a_verify_release: assert property (@(posedge clk) disable iff (rst)
    (!s_r.ce_n && !s_r.oe_n) |-> s_r.pd_oe_n && s_r.pgm_n)
    else $error("bus driven while device outputs");
  a_mode_held: assert property (@(posedge clk) disable iff (rst)
    (!s_r.ce_n || !s_r.oe_n || !s_r.pgm_n) |-> !s_r.prom_reset_n)
    else $error("strobe active outside programming mode");
  a_read_supply: assert property (@(posedge clk) disable iff (rst)
    (s_r.busy && s_r.op == PPI_OP_READ) |-> !s_r.vpp_high)
    else $error("high supply raised for read");
  a_retry_limit: assert property (@(posedge clk) disable iff (rst)
    s_r.tries < `PPI_MAX_TRIES)
    else $error("too many write attempts");
  a_addr_limit: assert property (@(posedge clk) disable iff (rst)
    !s_r.pgm_n |-> addr_ok(s_r.pa))
    else $error("pulse outside programmable range");
  a_done_idle: assert property (@(posedge clk) disable iff (rst)
    s_r.done |-> !s_r.busy && s_r.ce_n && s_r.oe_n && s_r.pgm_n
      ##1 (!s_r.done || $past(cmd_valid)))
    else $error("done not a standby pulse");
endmodule

// [test_ppi_prom_prog.sv]
// self-checking bench for the prom programming controller against the device model
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module test_ppi_prom_prog;
  import ppi_pkg::*;
  localparam int unsigned PULSE = 20;
  typedef struct packed {
    logic [1:0]  op;
    logic [16:0] addr;
    logic [7:0]  data;
    logic [4:0]  skip;
    logic        fail;
    logic [7:0]  rd;
    logic [3:0]  np;
  } ppi_row_t;
  logic clk = 0, rst = 1, cmd_valid = 0, pg_wr_en = 0;
  logic [1:0] cmd_op = 2'h3, pg_wr_idx = 2'h0;
  logic [16:0] cmd_addr = 17'h0_0000, pg_wr_addr = 17'h0_0000;
  logic [7:0] cmd_data = 8'h00, pg_wr_data = 8'h00;
  logic busy, done, fail, rd_blank, prom_reset_n, vpp_high, prom_enable_n;
  logic read_strobe_n, program_pulse_n, prog_data_oe_n, m_en;
  logic [7:0] rd_data, prog_data_out, prog_data_in, m_dq;
  logic [16:0] prog_address;
  logic [3:0] np;
  int n_fail = 0, n_compared = 0, p0 = 0;
  // ordinary cases: blank read, byte writes with retries, address limit, illegal op
  ppi_row_t rows [8] = '{
    '{2'h0, 17'h0_0010, 8'h00, 5'h00, 1'b0, 8'hff, 4'h0},
    '{2'h1, 17'h0_0010, 8'h5a, 5'h00, 1'b0, 8'h00, 4'h1},
    '{2'h0, 17'h0_0010, 8'h00, 5'h00, 1'b0, 8'h5a, 4'h0},
    '{2'h1, 17'h0_efff, 8'h3c, 5'h02, 1'b0, 8'h00, 4'h3},
    '{2'h0, 17'h0_efff, 8'h00, 5'h00, 1'b0, 8'h3c, 4'h0},
    '{2'h1, 17'h0_f000, 8'h00, 5'h00, 1'b1, 8'h00, 4'h0},
    '{2'h1, 17'h0_0020, 8'h11, 5'h1f, 1'b1, 8'h00, 4'ha},
    '{2'h3, 17'h0_0000, 8'h00, 5'h00, 1'b1, 8'h00, 4'h0}};

  // ----------------------------------------------------------------
  // design, device model and the shared data pins
  // ----------------------------------------------------------------
  ppi_prom_prog #(.PULSE_CYC(PULSE)) DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .pg_wr_en(pg_wr_en),
    .pg_wr_idx(pg_wr_idx), .pg_wr_addr(pg_wr_addr), .pg_wr_data(pg_wr_data), .busy(busy),
    .done(done), .fail(fail), .rd_data(rd_data), .rd_blank(rd_blank),
    .prom_reset_n(prom_reset_n), .vpp_high(vpp_high), .prom_enable_n(prom_enable_n),
    .read_strobe_n(read_strobe_n), .program_pulse_n(program_pulse_n),
    .prog_address(prog_address), .prog_data_out(prog_data_out),
    .prog_data_oe_n(prog_data_oe_n), .prog_data_in(prog_data_in));
  ppi_prom_model M (.clk(clk), .reset_n(prom_reset_n), .vpp_high(vpp_high),
    .enable_n(prom_enable_n), .read_n(read_strobe_n), .pgm_n(program_pulse_n),
    .addr(prog_address), .din(prog_data_in), .dq_en(m_en), .dq(m_dq));
  // the controller wins when it drives, otherwise the device side shows
  assign prog_data_in = prog_data_oe_n ? m_dq : prog_data_out;

  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // pin monitor, off the active edge so register updates have landed
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (!rst && !program_pulse_n) `CHK({prom_reset_n, vpp_high, prog_data_oe_n}, {2'b01, prom_enable_n})
    if (!rst && !read_strobe_n && !prom_enable_n) `CHK(prog_data_oe_n, 1'b1)
  end

  task automatic finish_test;
    $display("counts: compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one command, then a bounded wait for its done pulse
  task automatic run(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    p0 = M.pulses;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    // look after the edge has landed: a refused command shows done for one cycle only
    #1;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 20000) n_fail++;
    np = 4'(M.pulses - p0);
  endtask

  // four page entries, the third one optionally out of range
  task automatic load_page(input logic [16:0] base, input logic [16:0] bad);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      pg_wr_en <= 1'b1;
      pg_wr_idx <= 2'(k);
      pg_wr_addr <= (k == 2) ? bad : base + 17'(k);
      pg_wr_data <= 8'ha0 + 8'(k);
    end
    @(posedge clk);
    pg_wr_en <= 1'b0;
  endtask

  // watchdog sized well above the expected run of a few thousand cycles
  initial begin
    #1000000;
    n_fail++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK({program_pulse_n, read_strobe_n, prom_enable_n, prog_data_oe_n, vpp_high}, 5'h1e)
    foreach (rows[i]) begin
      M.skip = int'(rows[i].skip);
      run(rows[i].op, rows[i].addr, rows[i].data);
      `CHK({fail, np}, {rows[i].fail, rows[i].np})
      if (rows[i].op == 2'h0) `CHK({rd_data, rd_blank}, {rows[i].rd, rows[i].rd == 8'hff})
      if (np != 4'h0) `CHK(M.width, PULSE)
      $display("row %0d done", i);
    end
    // page write and read-back of every entry
    M.skip = 0;
    load_page(17'h0_0200, 17'h0_0202);
    run(2'h2, 17'h0_0000, 8'h00);
    `CHK({fail, np, M.width == PULSE}, {1'b0, 4'h1, 1'b1})
    for (int k = 0; k < 4; k++) begin
      run(2'h0, 17'h0_0200 + 17'(k), 8'h00);
      `CHK(rd_data, 8'ha0 + 8'(k))
    end
    $display("page test done");
    // entry past the last writable address must stop before any pulse
    load_page(17'h0_0300, 17'h0_f000);
    run(2'h2, 17'h0_0000, 8'h00);
    `CHK({fail, np}, {1'b1, 4'h0})
    $display("page limit test done");
    // reset in mid-pulse releases the bus and the strobes
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= 2'h1;
    cmd_addr <= 17'h0_0040;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (60) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    `CHK({prom_reset_n, program_pulse_n, prog_data_oe_n, vpp_high, busy}, 5'h1c)
    @(posedge clk);
    rst <= 1'b0;
    // a command straight after release still reads the earlier byte
    run(2'h0, 17'h0_0010, 8'h00);
    `CHK({fail, rd_data}, {1'b0, 8'h5a})
    $display("reset test done");
    finish_test();
  end
endmodule
